// ==== rsc_top.sv ====
// reset source controller: four reset sources, start-up stretch, cause flags,
// bandgap enable. detector inputs and strobes are synchronous to core_clk.
// Contract
// - reset I/O registers; fetch reset vector after
// - port reset immediate on any active source
// - delay counter stretches reset, fuse-selected length
// - exactly four sources; brown-out only when enabled
// - pin low past minimum width resets
// - pin release starts delay counter
// - power-on holds, delays on rise, immediate drop
// - three-bit level fuse, 111 disables detector
// - brown-out asserts immediately, delays on recovery
// - brown-out dips below minimum width ignored
// - watchdog pulse one cycle, delay after
// - cause bits 7..4 read zero
// - bit 3 watchdog, cleared power-on or write
// - bit 2 brown-out, cleared power-on or write
// - bit 1 pin, cleared power-on or write
// - bit 0 power-on, cleared only by write
// - bandgap on for detector, comparator, adc
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
module rsc_top #(
   parameter int cnt_width = 20,
   parameter int pin_min = rsc_pkg::pin_min_cycles,
   parameter int undervolt_min = rsc_pkg::undervolt_min_cycles
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // reset sources
   input wire logic supply_low,
   input wire logic reset_pin_n,
   input wire logic pin_reset_enable,
   input wire logic watchdog_timeout,
   input wire logic undervolt_trip,
   // fuses
   input wire logic [2:0] undervolt_level_fuses,
   input wire logic [1:0] startup_time_fuses,
   input wire logic [3:0] clock_select_fuses,
   input wire logic [cnt_width-1:0] delay_cycles,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // reset outputs
   output logic port_reset,
   output logic internal_reset,
   output logic fetch_vector,
   // bandgap
   output logic bandgap_enable
);
   logic pin_active;
   logic undervolt_active;
   logic undervolt_enabled;
   logic any_source;
   logic reset_hold;
   logic [3:0] cause;
   logic [7:0] control;
   logic internal_reset_q;
   logic [7:0] next_rdata;
   rsc_pkg::rsc_state_type delay_state;

   // detector enabled unless fuse code disables it
   assign undervolt_enabled = (undervolt_level_fuses != rsc_pkg::undervolt_off_code);

   rsc_filter #(
      .min_cycles(pin_min)
   ) u_pin_filter (
      .core_clk(core_clk),
      .rst(rst),
      .raw_active(pin_reset_enable && !reset_pin_n),
      .filt_active(pin_active)
   );

   rsc_filter #(
      .min_cycles(undervolt_min)
   ) u_undervolt_filter (
      .core_clk(core_clk),
      .rst(rst),
      .raw_active(undervolt_enabled && undervolt_trip),
      .filt_active(undervolt_active)
   );

   // combined source level
   assign any_source = supply_low || pin_active || watchdog_timeout
      || (undervolt_active && undervolt_enabled);

   // fuse inputs select delay_cycles externally; delay state visible on status read
   rsc_delay #(
      .cnt_width(cnt_width)
   ) u_delay (
      .core_clk(core_clk),
      .rst(rst),
      .any_source(any_source),
      .delay_cycles(delay_cycles),
      .reset_hold(reset_hold),
      .state(delay_state)
   );

   // port reset follows sources one clock later, without stretch
   always_ff @(posedge core_clk) begin
      if (rst) begin
         port_reset <= 1'b1;
      end else begin
         port_reset <= any_source;
      end
   end

   // internal reset and vector fetch
   always_ff @(posedge core_clk) begin
      if (rst) begin
         internal_reset <= 1'b1;
         internal_reset_q <= 1'b1;
         fetch_vector <= 1'b0;
      end else begin
         internal_reset <= reset_hold || any_source;
         internal_reset_q <= internal_reset;
         fetch_vector <= internal_reset_q && !internal_reset;
      end
   end

   // cause flags: set wins over software clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cause <= 4'h1;
      end else begin
         if (reg_write && reg_addr == rsc_pkg::cause_flags_addr) begin
            cause <= cause & reg_wdata[3:0];
         end
         if (supply_low) begin
            cause <= 4'h1;
         end else begin
            if (watchdog_timeout) begin
               cause[rsc_pkg::watchdog_bit] <= 1'b1;
            end
            if (undervolt_active && undervolt_enabled) begin
               cause[rsc_pkg::undervolt_bit] <= 1'b1;
            end
            if (pin_active) begin
               cause[rsc_pkg::pin_bit] <= 1'b1;
            end
         end
      end
   end

   // control register: comparator bandgap select and adc enable
   always_ff @(posedge core_clk) begin
      if (rst || internal_reset) begin
         control <= rsc_pkg::control_reset;
      end else if (reg_write && reg_addr == rsc_pkg::control_addr) begin
         control <= reg_wdata;
      end
   end

   // bandgap enable
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bandgap_enable <= 1'b0;
      end else begin
         bandgap_enable <= undervolt_enabled || control[rsc_pkg::comp_bg_bit]
            || control[rsc_pkg::adc_en_bit];
      end
   end

   // read mux
   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr)
         rsc_pkg::cause_flags_addr: next_rdata = {4'h0, cause};
         rsc_pkg::control_addr: next_rdata = {6'h00, control[1:0]};
         rsc_pkg::status_addr: next_rdata = {2'h0, delay_state, internal_reset,
            undervolt_enabled, undervolt_active, pin_active};
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule : rsc_top

// ==== rsc_pkg.sv ====
// package for the reset source controller: register map, field layout and timing.
// assumes a 125 mhz core_clk; used by rsc_top and rsc_delay, not by rsc_filter.
package rsc_pkg;
   // register map
   localparam logic [7:0] cause_flags_addr = 8'h34;
   localparam logic [7:0] control_addr = 8'h35;
   localparam logic [7:0] status_addr = 8'h36;
   // reset cause flag positions
   localparam int powerup_bit = 0;
   localparam int pin_bit = 1;
   localparam int undervolt_bit = 2;
   localparam int watchdog_bit = 3;
   localparam logic [3:0] cause_mask = 4'hf;
   // control register fields
   localparam int comp_bg_bit = 0;
   localparam int adc_en_bit = 1;
   localparam logic [7:0] control_reset = 8'h00;
   // fuse codes
   localparam logic [2:0] undervolt_off_code = 3'h7;
   // timing
   localparam int clk_period_ps = 8000;
   localparam int pin_min_pulse_ps = 900000;
   localparam int undervolt_min_pulse_ps = 2000000;
   localparam int pin_min_cycles = (pin_min_pulse_ps + clk_period_ps - 1) / clk_period_ps;
   localparam int undervolt_min_cycles =
      (undervolt_min_pulse_ps + clk_period_ps - 1) / clk_period_ps;
   localparam int bandgap_startup_us = 70;
   // start-up delay states
   typedef enum logic [1:0] {
      st_hold = 2'b00,
      st_count = 2'b01,
      st_run = 2'b10
   } rsc_state_type;
endpackage : rsc_pkg

// ==== rsc_filter.sv ====
// filter: output goes active only after input stayed active for min_cycles + 1 clocks.
// input is synchronous to core_clk.
`timescale 1ns/10ps
module rsc_filter #(
   parameter int min_cycles = 113
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // level in and filtered level out
   input wire logic raw_active,
   output logic filt_active
);
   localparam int cw = $clog2(min_cycles + 1);
   logic [cw-1:0] count;

   always_ff @(posedge core_clk) begin
      if (rst || !raw_active) begin
         count <= '0;
         filt_active <= 1'b0;
      end else if (count >= cw'(min_cycles)) begin
         filt_active <= 1'b1;
      end else begin
         count <= count + cw'(1);
      end
   end
endmodule : rsc_filter

// ==== rsc_delay.sv ====
// start-up delay counter: stretches internal reset after all sources go quiet.
// length is selected from the fuse table passed in as a count.
`timescale 1ns/10ps
module rsc_delay #(
   parameter int cnt_width = 20
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // any source active, and stretch length
   input wire logic any_source,
   input wire logic [cnt_width-1:0] delay_cycles,
   // stretched reset
   output logic reset_hold,
   output rsc_pkg::rsc_state_type state
);
   logic [cnt_width-1:0] count;

   always_ff @(posedge core_clk) begin
      if (rst || any_source) begin
         state <= rsc_pkg::st_hold;
         count <= '0;
         reset_hold <= 1'b1;
      end else begin
         case (state)
            rsc_pkg::st_hold: begin
               state <= rsc_pkg::st_count;
               count <= '0;
            end
            rsc_pkg::st_count: begin
               if (count >= delay_cycles) begin
                  state <= rsc_pkg::st_run;
                  reset_hold <= 1'b0;
               end else begin
                  count <= count + cnt_width'(1);
               end
            end
            rsc_pkg::st_run: reset_hold <= 1'b0;
            default: state <= rsc_pkg::st_hold;
         endcase
      end
   end
endmodule : rsc_delay

// ==== rsc_asserts.sv ====
// checker for rsc_top: reset source, stretch, fetch and register rules.
// assumes sim parameters pin_min and undervolt_min below 7, delay_cycles above 8.
`timescale 1ns/10ps
module rsc_asserts (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // sources and fuses
   input wire logic supply_low,
   input wire logic reset_pin_n,
   input wire logic pin_reset_enable,
   input wire logic watchdog_timeout,
   input wire logic undervolt_trip,
   input wire logic [2:0] undervolt_level_fuses,
   // register port and outputs
   input wire logic [7:0] reg_addr,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic port_reset,
   input wire logic internal_reset,
   input wire logic fetch_vector,
   input wire logic bandgap_enable
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_pin_low;
      (!reset_pin_n && pin_reset_enable) [*8];
   endsequence
   sequence s_release;
      $fell(internal_reset) ##[0:1] fetch_vector;
   endsequence
   a_por_port: assert property (supply_low |=> port_reset) else $error("port reset late");
   a_por_hold: assert property (supply_low |=> internal_reset) else $error("por no hold");
   a_wd_reset: assert property (watchdog_timeout |=> port_reset) else $error("wd no reset");
   a_pin_reset: assert property (s_pin_low |=> port_reset) else $error("pin no reset");
   a_bo_reset: assert property ((undervolt_trip && undervolt_level_fuses != 3'h7) [*8]
      |=> port_reset) else $error("bo no reset");
   a_delay_stretch: assert property ($fell(port_reset) |-> internal_reset [*8])
      else $error("stretch short");
   a_fetch_pulse: assert property ($fell(internal_reset) |-> s_release)
      else $error("no fetch");
   a_bg_enable: assert property ((undervolt_level_fuses != 3'h7) |=> bandgap_enable)
      else $error("bandgap off");
   a_rd_upper: assert property ((reg_read && reg_addr == rsc_pkg::cause_flags_addr)
      |=> reg_rdata[7:4] == 4'h0) else $error("upper bits set");
endmodule : rsc_asserts
bind rsc_top rsc_asserts u_chk (.core_clk, .rst, .supply_low, .reset_pin_n,
   .pin_reset_enable, .watchdog_timeout, .undervolt_trip, .undervolt_level_fuses,
   .reg_addr, .reg_read, .reg_rdata, .port_reset, .internal_reset, .fetch_vector,
   .bandgap_enable);

// ==== rsc_src_model.sv ====
// model of supply monitors, reset pin and watchdog.
// assumes the caller waits between calls; lines go idle after each call.
`timescale 1ns/10ps
module rsc_src_model (
   // clock
   input wire logic core_clk,
   // source levels
   output logic supply_low,
   output logic reset_pin_n,
   output logic watchdog_timeout,
   output logic undervolt_trip
);
   initial begin
      supply_low = 1'b0;
      reset_pin_n = 1'b1;
      watchdog_timeout = 1'b0;
      undervolt_trip = 1'b0;
   end
   // kind 0 por, 1 pin, 2 watchdog, 3 brown-out, active for n cycles
   task automatic fire(input int kind, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         case (kind)
            0: supply_low <= 1'b1;
            1: reset_pin_n <= 1'b0;
            2: watchdog_timeout <= 1'b1;
            default: undervolt_trip <= 1'b1;
         endcase
      end
      @(posedge core_clk);
      supply_low <= 1'b0;
      reset_pin_n <= 1'b1;
      watchdog_timeout <= 1'b0;
      undervolt_trip <= 1'b0;
   endtask : fire
endmodule : rsc_src_model

// ==== test_reset_source_controller.sv ====
// testbench for rsc_top: sources from the model, registers via the plain port.
// assumes pin_min and undervolt_min of 4 and a stretch of 10, later 9, cycles.
`timescale 1ns/10ps
module test_reset_source_controller;
   logic core_clk = 1'b0, rst = 1'b1, pin_en = 1'b0, fetch_seen = 1'b0;
   logic [2:0] fz = 3'h7;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_write = 1'b0, reg_read = 1'b0, slow, pin_n, wd, trip;
   logic [19:0] dly = 20'h0000a;
   logic port_reset, internal_reset, fetch_vector, bandgap_enable;
   int fail_count = 0, n_tests = 0, cyc = 0;
   always #4 core_clk = ~core_clk;
   rsc_src_model u_src (.core_clk(core_clk), .supply_low(slow), .reset_pin_n(pin_n),
      .watchdog_timeout(wd), .undervolt_trip(trip));
   rsc_top #(.cnt_width(20), .pin_min(4), .undervolt_min(4)) u_dut (.core_clk(core_clk),
      .rst(rst), .supply_low(slow), .reset_pin_n(pin_n), .pin_reset_enable(pin_en),
      .watchdog_timeout(wd), .undervolt_trip(trip), .undervolt_level_fuses(fz),
      .startup_time_fuses(2'h0), .clock_select_fuses(4'h0), .delay_cycles(dly),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .port_reset(port_reset),
      .internal_reset(internal_reset), .fetch_vector(fetch_vector),
      .bandgap_enable(bandgap_enable));
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (fetch_vector === 1'b1) fetch_seen <= 1'b1;
      if (cyc == 20000) begin
         fail_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1 chk("rdata", exp, reg_rdata);
   endtask : rd
   task automatic wait_rel();
      int k = 0;
      repeat (2) @(posedge core_clk);
      while (internal_reset !== 1'b0 && k < 300) begin
         @(posedge core_clk);
         k++;
      end
      chk("release", 8'h01, {7'h00, k < 300});
   endtask : wait_rel
   task automatic stretch(input logic [7:0] exp);
      int n = 0;
      int k = 0;
      @(posedge core_clk);
      #1;
      while (port_reset !== 1'b0 && k < 300) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      while (internal_reset !== 1'b0 && k < 300) begin
         n++;
         @(posedge core_clk);
         #1;
         k++;
      end
      chk("stretch", exp, 8'(n));
   endtask : stretch
   task automatic bg(input logic [7:0] exp);
      repeat (2) @(posedge core_clk);
      #1 chk("bandgap", exp, {7'h00, bandgap_enable});
   endtask : bg
   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      wait_rel();
      rd(8'h34, 8'h01);
      chk("fetch", 8'h01, {7'h00, fetch_seen});
      wr(8'h34, 8'h00);
      rd(8'h34, 8'h00);
      u_src.fire(1, 8);
      @(posedge core_clk) pin_en <= 1'b1;
      u_src.fire(1, 2);
      u_src.fire(3, 8);
      rd(8'h34, 8'h00);
      bg(8'h00);
      wr(8'h35, 8'h01);
      bg(8'h01);
      wr(8'h35, 8'h02);
      bg(8'h01);
      rd(8'h35, 8'h02);
      wr(8'h35, 8'h00);
      bg(8'h00);
      @(posedge core_clk) fz <= 3'h6;
      bg(8'h01);
      u_src.fire(3, 2);
      rd(8'h34, 8'h00);
      u_src.fire(3, 8);
      wait_rel();
      rd(8'h34, 8'h04);
      u_src.fire(2, 1);
      wait_rel();
      rd(8'h34, 8'h0c);
      u_src.fire(2, 1);
      repeat (4) @(posedge core_clk);
      u_src.fire(2, 1);
      stretch(8'd12);
      @(posedge core_clk) dly <= 20'h00009;
      u_src.fire(2, 1);
      stretch(8'd11);
      rd(8'h36, 8'h24);
      u_src.fire(1, 8);
      wait_rel();
      rd(8'h34, 8'h0e);
      wr(8'h35, 8'h01);
      u_src.fire(0, 4);
      wait_rel();
      rd(8'h34, 8'h01);
      rd(8'h35, 8'h00);
      wr(8'h34, 8'hff);
      rd(8'h34, 8'h01);
      rd(8'h40, 8'h00);
      end_sim();
   end
endmodule : test_reset_source_controller
